/* hdl/sbl_loader.sv */
// top: boot loader mode control, baud measurement, load sequence and fetch redirect
// Functional notes
// - enter mode when strap low at hardware reset
// - wait for zero byte on receive line
// - drive transmit line, send identification byte
// - watchdog disabled while mode active
// - external access pin ignored in mode
// - code fetches to flash go to boot ROM
// - data reads of flash area hit user flash
// - redirect follows flash mapped to segment one
// - romless data reads may be undefined
// - store 32 bytes at FA40h to FA5Fh
// - then jump to FA40h
// - mode persists after the jump
// - software reset always leaves the mode
// - hardware reset, strap high: normal start
// - time zero byte with measurement timer
// - reload equals count minus 36 over 72
// - timer overflow spoils serial setup
`timescale 1ns/1ps
module sbl_loader
#(
  parameter logic [7:0] IDENT = sbl_pkg::IDENT_BYTE, // arbitrary value
  parameter bit HAS_FLASH = 1'b1
)
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_SW_RESET,
  input wire logic I_BOOT_STRAP_PIN,
  input wire logic I_EXTERNAL_ACCESS_PIN,
  input wire logic I_FLASH_IN_SEG1,
  input wire logic I_SERIAL_RECEIVE_LINE,
  input wire sbl_pkg::sbl_fetch_s I_FETCH,
  output logic O_SERIAL_TRANSMIT_LINE,
  output logic O_SERIAL_TRANSMIT_OE_N,
  output logic O_BOOT_LOADER_MODE,
  output logic O_WATCHDOG_ENABLE,
  output logic O_USE_EXTERNAL_MEM,
  output logic O_BOOT_ROM_SELECT,
  output logic O_DATA_UNDEFINED,
  output sbl_pkg::sbl_ram_wr_s O_RAM_WR,
  output logic O_JUMP,
  output logic [23:0] O_JUMP_ADDR,
  output logic O_BAUD_ERROR,
  output logic [15:0] O_BAUD_RELOAD_VALUE
);
  typedef enum logic [5:0]
  {
    S_IDLE = 6'b000001,
    S_WAIT_LOW = 6'b000010,
    S_MEASURE = 6'b000100,
    S_SEND_ID = 6'b001000,
    S_LOAD = 6'b010000,
    S_RUN = 6'b100000
  } sbl_state_e;

  typedef struct packed {
    sbl_state_e state;
    logic [2:0] rx_sync;
    logic rx_level;
    logic [1:0] pre;
    logic [15:0] timer;
    logic [1:0] highs;
    logic mode;
    logic wdt_en;
    logic [5:0] count;
    logic tx_start;
    logic tx_oe_n;
    logic rx_en;
    logic baud_err;
    logic [15:0] reload;
    logic boot_sel;
    logic undef;
    logic use_ext;
    logic jump;
    logic [23:0] jump_addr;
    sbl_pkg::sbl_ram_wr_s wr;
  } sbl_top_s;

  sbl_top_s st;
  sbl_top_s next_st;
  logic tx_line;
  logic tx_done;
  sbl_pkg::sbl_byte_s rx_byte;

  // flash window check, shared by both segment mappings
  function automatic logic in_flash(input logic [23:0] a, input logic seg1);
    logic [23:0] lo;
    logic [23:0] hi;
    lo = seg1 ? sbl_pkg::FLASH_SEG1_LO : sbl_pkg::FLASH_SEG0_LO;
    hi = seg1 ? sbl_pkg::FLASH_SEG1_HI : sbl_pkg::FLASH_SEG0_HI;
    in_flash = (a >= lo) && (a <= hi);
  endfunction

  // reload = (count - 36) / 72; counts under 36 clamp to zero
  function automatic logic [15:0] calc_reload(input logic [15:0] t);
    logic [15:0] d;
    d = (t > sbl_pkg::MEAS_OFFSET) ? t - sbl_pkg::MEAS_OFFSET : 16'h0000;
    calc_reload = d / sbl_pkg::MEAS_DIV;
  endfunction

  sbl_uart_rx u_rx
  (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_en(st.rx_en),
    .i_rx(st.rx_level),
    .i_reload(st.reload),
    .o_byte(rx_byte)
  );

  sbl_uart_tx u_tx
  (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_start(st.tx_start),
    .i_data(IDENT),
    .i_reload(st.reload),
    .o_tx(tx_line),
    .o_done(tx_done)
  );

  // receive pin passes three stages; a level counts when stages two and three agree
  always_comb
  begin
    next_st = st;
    next_st.rx_sync = {st.rx_sync[1:0], I_SERIAL_RECEIVE_LINE};
    if (st.rx_sync[2] == st.rx_sync[1])
    begin
      next_st.rx_level = st.rx_sync[2];
    end
    next_st.tx_start = 1'b0;
    next_st.jump = 1'b0;
    next_st.wr.we = 1'b0;
    // redirect only code fetches; data reads see user flash
    next_st.boot_sel = st.mode && I_FETCH.code_fetch
      && in_flash(I_FETCH.addr, I_FLASH_IN_SEG1);
    next_st.undef = st.mode && !HAS_FLASH && !I_FETCH.code_fetch
      && in_flash(I_FETCH.addr, I_FLASH_IN_SEG1);
    next_st.use_ext = st.mode ? 1'b0 : !I_EXTERNAL_ACCESS_PIN;
    if (I_SW_RESET)
    begin
      next_st.mode = 1'b0;
      next_st.state = S_IDLE;
      next_st.rx_en = 1'b0;
      next_st.tx_oe_n = 1'b1;
      next_st.jump = 1'b1;
      next_st.jump_addr = sbl_pkg::RESET_VECTOR;
    end
    else
    begin
      unique case (st.state)
        S_IDLE:
        begin
          if (st.mode)
          begin
            next_st.state = S_WAIT_LOW;
            next_st.highs = 2'h0;
          end
        end
        S_WAIT_LOW:
        begin
          // need idle high before the start bit counts
          if (st.rx_level && st.highs != 2'h3)
          begin
            next_st.highs = st.highs + 2'h1;
          end
          if (!st.rx_level && st.highs == 2'h3)
          begin
            next_st.state = S_MEASURE;
            next_st.timer = 16'h0000;
            next_st.pre = 2'h0;
          end
        end
        S_MEASURE:
        begin
          // timer ticks every fourth clock; line low spans start plus eight zero bits
          next_st.pre = st.pre + 2'h1;
          if (st.pre == sbl_pkg::MEAS_PRESCALE)
          begin
            if (st.timer == 16'hFFFF)
            begin
              next_st.baud_err = 1'b1;
            end
            next_st.timer = st.timer + 16'h0001;
          end
          if (st.rx_level)
          begin
            next_st.reload = calc_reload(st.timer);
            next_st.state = S_SEND_ID;
            next_st.tx_start = 1'b1;
            next_st.tx_oe_n = 1'b0;
          end
        end
        S_SEND_ID:
        begin
          if (tx_done)
          begin
            next_st.state = S_LOAD;
            next_st.rx_en = 1'b1;
            next_st.count = 6'h00;
          end
        end
        S_LOAD:
        begin
          if (rx_byte.valid)
          begin
            next_st.wr.we = 1'b1;
            next_st.wr.addr = sbl_pkg::LOAD_BASE + {18'h00000, st.count};
            next_st.wr.data = rx_byte.data;
            next_st.count = st.count + 6'h01;
            if (st.count == sbl_pkg::LOAD_COUNT - 6'h01)
            begin
              next_st.state = S_RUN;
            end
          end
        end
        S_RUN:
        begin
          // one-shot jump after the final store; mode and receiver stay on
          if (!st.jump && st.jump_addr != sbl_pkg::LOAD_BASE)
          begin
            next_st.jump = 1'b1;
            next_st.jump_addr = sbl_pkg::LOAD_BASE;
          end
        end
        default:
        begin
          next_st.state = S_IDLE;
        end
      endcase
    end
    next_st.wdt_en = !next_st.mode;
  end

  // strap is caught on the clocked release of the hardware reset
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      st <= '0;
      st.state <= S_IDLE;
      st.rx_sync <= 3'h7;
      st.rx_level <= 1'b1;
      st.tx_oe_n <= 1'b1;
      st.jump_addr <= sbl_pkg::RESET_VECTOR;
      st.mode <= !I_BOOT_STRAP_PIN;
      st.wdt_en <= I_BOOT_STRAP_PIN;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign O_SERIAL_TRANSMIT_LINE = tx_line;
  assign O_SERIAL_TRANSMIT_OE_N = st.tx_oe_n;
  assign O_BOOT_LOADER_MODE = st.mode;
  assign O_WATCHDOG_ENABLE = st.wdt_en;
  assign O_USE_EXTERNAL_MEM = st.use_ext;
  assign O_BOOT_ROM_SELECT = st.boot_sel;
  assign O_DATA_UNDEFINED = st.undef;
  assign O_RAM_WR = st.wr;
  assign O_JUMP = st.jump;
  assign O_JUMP_ADDR = st.jump_addr;
  assign O_BAUD_ERROR = st.baud_err;
  assign O_BAUD_RELOAD_VALUE = st.reload;

  property p_wdt_off;
    @(posedge I_SYS_CLK) disable iff (I_RESET) st.mode |-> !O_WATCHDOG_ENABLE;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog on in mode");

  property p_code_redirect;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      (st.mode && !I_SW_RESET && I_FETCH.code_fetch && !I_FLASH_IN_SEG1
      && I_FETCH.addr <= sbl_pkg::FLASH_SEG0_HI) |=> O_BOOT_ROM_SELECT;
  endproperty
  a_code_redirect: assert property (p_code_redirect) else $error("no redirect");

  property p_data_flash;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      !I_FETCH.code_fetch |=> !O_BOOT_ROM_SELECT;
  endproperty
  a_data_flash: assert property (p_data_flash) else $error("data read redirected");

  property p_seg1;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      (st.mode && I_FETCH.code_fetch && I_FLASH_IN_SEG1
      && I_FETCH.addr >= sbl_pkg::FLASH_SEG1_LO
      && I_FETCH.addr <= sbl_pkg::FLASH_SEG1_HI) |=> O_BOOT_ROM_SELECT;
  endproperty
  a_seg1: assert property (p_seg1) else $error("segment one not redirected");

  property p_ea_ignored;
    @(posedge I_SYS_CLK) disable iff (I_RESET) st.mode |=> !O_USE_EXTERNAL_MEM;
  endproperty
  a_ea_ignored: assert property (p_ea_ignored) else $error("external pin used");

  property p_sw_exit;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      I_SW_RESET |=> !O_BOOT_LOADER_MODE && O_JUMP && O_JUMP_ADDR == sbl_pkg::RESET_VECTOR;
  endproperty
  a_sw_exit: assert property (p_sw_exit) else $error("mode kept after sw reset");

  sequence s_last_store;
    st.state == S_LOAD && rx_byte.valid && st.count == sbl_pkg::LOAD_COUNT - 6'h01;
  endsequence
  property p_jump;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      s_last_store ##1 !I_SW_RESET |=> O_JUMP && O_JUMP_ADDR == sbl_pkg::LOAD_BASE && O_BOOT_LOADER_MODE;
  endproperty
  a_jump: assert property (p_jump) else $error("no jump to loaded code");

  property p_store_range;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      O_RAM_WR.we |-> O_RAM_WR.addr >= sbl_pkg::LOAD_BASE
      && O_RAM_WR.addr <= sbl_pkg::LOAD_BASE + 24'(sbl_pkg::LOAD_COUNT) - 24'h000001;
  endproperty
  a_store_range: assert property (p_store_range) else $error("store out of range");

  property p_rx_after_id;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      (st.state == S_SEND_ID && tx_done && !I_SW_RESET) |=> st.rx_en;
  endproperty
  a_rx_after_id: assert property (p_rx_after_id) else $error("receiver late");
endmodule

/* hdl/sbl_pkg.sv */
// package: constants and carrier types for the serial boot loader block
package sbl_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int ADDR_W = 24;
  localparam logic [23:0] FLASH_SEG0_LO = 24'h000000;
  localparam logic [23:0] FLASH_SEG0_HI = 24'h007FFF;
  localparam logic [23:0] FLASH_SEG1_LO = 24'h010000;
  localparam logic [23:0] FLASH_SEG1_HI = 24'h017FFF;
  localparam logic [23:0] LOAD_BASE = 24'h00FA40;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  localparam logic [5:0] LOAD_COUNT = 6'h20;
  localparam logic [15:0] MEAS_OFFSET = 16'h0024;
  localparam logic [15:0] MEAS_DIV = 16'h0048;
  localparam logic [4:0] OVERSAMPLE = 5'h1F;
  localparam logic [4:0] MID_SAMPLE = 5'h0F;
  localparam logic [3:0] FRAME_BITS = 4'h9;
  localparam logic [1:0] MEAS_PRESCALE = 2'h3;
  localparam logic [7:0] IDENT_BYTE = 8'hA6;

  typedef struct packed {
    logic [23:0] addr;
    logic code_fetch;
  } sbl_fetch_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sbl_byte_s;

  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [7:0] data;
  } sbl_ram_wr_s;
endpackage

/* hdl/sbl_uart_rx.sv */
// receiver: 32x-oversampled asynchronous byte receiver
`timescale 1ns/1ps
module sbl_uart_rx
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_en,
  input wire logic i_rx,
  input wire logic [15:0] i_reload,
  output sbl_pkg::sbl_byte_s o_byte
);
  typedef struct packed {
    logic busy;
    logic [15:0] pre;
    logic [4:0] tick;
    logic [3:0] bit_n;
    logic [7:0] shreg;
    sbl_pkg::sbl_byte_s out;
  } sbl_rx_s;

  sbl_rx_s st;
  sbl_rx_s next_st;

  // sample at mid bit; the rate is clk / (32 * (reload + 1))
  always_comb
  begin
    next_st = st;
    next_st.out.valid = 1'b0;
    if (!i_en)
    begin
      next_st.busy = 1'b0;
    end
    else if (!st.busy)
    begin
      if (!i_rx)
      begin
        next_st.busy = 1'b1;
        next_st.pre = i_reload;
        next_st.tick = sbl_pkg::MID_SAMPLE;
        next_st.bit_n = 4'h0;
      end
    end
    else if (st.pre != 16'h0000)
    begin
      next_st.pre = st.pre - 16'h0001;
    end
    else
    begin
      next_st.pre = i_reload;
      if (st.tick != 5'h00)
      begin
        next_st.tick = st.tick - 5'h01;
      end
      else
      begin
        next_st.tick = sbl_pkg::OVERSAMPLE;
        next_st.bit_n = st.bit_n + 4'h1;
        if (st.bit_n == 4'h0 && i_rx)
        begin
          next_st.busy = 1'b0; // false start, drop it
        end
        else if (st.bit_n == sbl_pkg::FRAME_BITS)
        begin
          next_st.busy = 1'b0;
          next_st.out.valid = i_rx; // framing error drops the byte
          next_st.out.data = st.shreg;
        end
        else if (st.bit_n != 4'h0)
        begin
          next_st.shreg = {i_rx, st.shreg[7:1]};
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_byte = st.out;
endmodule

/* hdl/sbl_uart_tx.sv */
// transmitter: one byte, 8N1, at the derived rate
`timescale 1ns/1ps
module sbl_uart_tx
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire logic [15:0] i_reload,
  output logic o_tx,
  output logic o_done
);
  typedef struct packed {
    logic busy;
    logic [15:0] pre;
    logic [4:0] tick;
    logic [3:0] bit_n;
    logic [9:0] shreg;
    logic done;
  } sbl_tx_s;

  sbl_tx_s st;
  sbl_tx_s next_st;

  // frame is start, eight data lsb first, stop; line idles high
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (!st.busy)
    begin
      next_st.shreg = {10{1'b1}};
      if (i_start)
      begin
        next_st.busy = 1'b1;
        next_st.shreg = {1'b1, i_data, 1'b0};
        next_st.pre = i_reload;
        next_st.tick = sbl_pkg::OVERSAMPLE;
        next_st.bit_n = 4'h0;
      end
    end
    else if (st.pre != 16'h0000)
    begin
      next_st.pre = st.pre - 16'h0001;
    end
    else
    begin
      next_st.pre = i_reload;
      if (st.tick != 5'h00)
      begin
        next_st.tick = st.tick - 5'h01;
      end
      else
      begin
        next_st.tick = sbl_pkg::OVERSAMPLE;
        next_st.shreg = {1'b1, st.shreg[9:1]};
        next_st.bit_n = st.bit_n + 4'h1;
        if (st.bit_n == sbl_pkg::FRAME_BITS)
        begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st <= '0;
      st.shreg <= {10{1'b1}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_tx = st.shreg[0];
  assign o_done = st.done;
endmodule

/* tb/sbl_host.sv */
// host model: sends boot frames on the receive line and reads the reply byte
`timescale 1ns/1ps
module sbl_host
#(
  parameter int BIT_CLKS = 64
)
(
  input wire logic i_clk,
  input wire logic i_tx,
  output logic o_rx
);
  // line idles high; a real host drives its transmitter high between frames
  initial o_rx = 1'b1;

  // one 8N1 frame, lsb first; each bit held BIT_CLKS clocks
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge i_clk);
      o_rx <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge i_clk);
    end
  endtask

  // waits a bounded time for a start bit, samples each bit at its middle
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    n = 0;
    while (i_tx !== 1'b0 && n < 20000)
    begin
      @(posedge i_clk);
      n++;
    end
    if (i_tx === 1'b0)
    begin
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CLKS) @(posedge i_clk);
        b[i] = i_tx;
      end
      repeat (BIT_CLKS) @(posedge i_clk);
      ok = (i_tx === 1'b1);
    end
  endtask
endmodule

/* tb/testbench.sv */
// testbench: fetch redirect table, boot load sequence, mode exit by software reset and strap-high normal start
`timescale 1ns/1ps
module testbench;
  localparam int BIT_CLKS = 64; // exact device rate for reload 1: 32 * (1 + 1)
  typedef struct packed {
    logic [23:0] addr;
    logic code;
    logic seg1;
    logic rom;
  } sbl_row_s;
  // flash window edges in both segment mappings, code and data accesses
  localparam sbl_row_s ROWS [8] = '{
    '{24'h000000, 1'b1, 1'b0, 1'b1}, '{24'h007FFF, 1'b1, 1'b0, 1'b1},
    '{24'h008000, 1'b1, 1'b0, 1'b0}, '{24'h007FFF, 1'b0, 1'b0, 1'b0},
    '{24'h010000, 1'b1, 1'b1, 1'b1}, '{24'h017FFF, 1'b1, 1'b1, 1'b1},
    '{24'h018000, 1'b1, 1'b1, 1'b0}, '{24'h010000, 1'b0, 1'b1, 1'b0}};

  logic clk, rst, sw_rst, strap, ea, seg1, rx;
  sbl_pkg::sbl_fetch_s fetch;
  sbl_pkg::sbl_ram_wr_s ram_wr;
  logic tx, tx_oe_n, mode, wdt_en, use_ext, rom_sel, undef, jump, baud_err;
  logic [23:0] jump_addr, last_jump;
  logic [15:0] reload;
  int mismatches = 0;
  int total_checks = 0;
  int wr_count = 0;
  int jump_seen = 0;

  sbl_loader dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_SW_RESET(sw_rst),
    .I_BOOT_STRAP_PIN(strap), .I_EXTERNAL_ACCESS_PIN(ea), .I_FLASH_IN_SEG1(seg1),
    .I_SERIAL_RECEIVE_LINE(rx), .I_FETCH(fetch), .O_SERIAL_TRANSMIT_LINE(tx),
    .O_SERIAL_TRANSMIT_OE_N(tx_oe_n), .O_BOOT_LOADER_MODE(mode),
    .O_WATCHDOG_ENABLE(wdt_en), .O_USE_EXTERNAL_MEM(use_ext), .O_BOOT_ROM_SELECT(rom_sel),
    .O_DATA_UNDEFINED(undef), .O_RAM_WR(ram_wr), .O_JUMP(jump), .O_JUMP_ADDR(jump_addr),
    .O_BAUD_ERROR(baud_err), .O_BAUD_RELOAD_VALUE(reload));
  sbl_host #(.BIT_CLKS(BIT_CLKS)) host (.i_clk(clk), .i_tx(tx), .o_rx(rx));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 5);
  endfunction

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // every stored byte must land in order from the load base
  always @(posedge clk)
  begin
    if (ram_wr.we === 1'b1)
    begin
      check(ram_wr.addr, 24'(sbl_pkg::LOAD_BASE + wr_count));
      check({16'h0000, ram_wr.data}, {16'h0000, pat(wr_count)});
      wr_count++;
    end
    if (jump === 1'b1)
    begin
      jump_seen++;
      last_jump <= jump_addr;
    end
  end

  // hang guard: a stuck sequence still reaches the verdict
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial
  begin
    logic [7:0] id;
    logic ok;
    int n;
    rst = 1'b1;
    sw_rst = 1'b0;
    strap = 1'b0;
    ea = 1'b0;
    seg1 = 1'b0;
    fetch = '0;
    repeat (5) @(posedge clk);
    #1;
    check(tx, 1'b1);
    check(tx_oe_n, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(mode, 1'b1);
    check(wdt_en, 1'b0);
    for (int r = 0; r < 8; r++)
    begin
      @(posedge clk);
      fetch <= '{ROWS[r].addr, ROWS[r].code};
      seg1 <= ROWS[r].seg1;
      @(posedge clk);
      #1;
      check(rom_sel, ROWS[r].rom);
      check(use_ext, 1'b0);
      check(undef, 1'b0);
    end
    // zero byte out, identification back in, both in parallel
    fork
      host.send_byte(8'h00);
      host.recv_byte(id, ok);
    join
    check(id, sbl_pkg::IDENT_BYTE);
    check(ok, 1'b1);
    check(tx_oe_n, 1'b0);
    check(reload, 16'h0001);
    check(baud_err, 1'b0);
    // the block follows at once, so no settling gap beyond one bit
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < 32; i++)
      host.send_byte(pat(i));
    n = 0;
    while (jump_seen == 0 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    check(wr_count, 32);
    check(jump_seen, 1);
    check(last_jump, sbl_pkg::LOAD_BASE);
    check(mode, 1'b1);
    check(wdt_en, 1'b0);
    // software reset leaves the mode although the strap is still low
    @(posedge clk);
    sw_rst <= 1'b1;
    fetch <= '{24'h010000, 1'b1};
    @(posedge clk);
    sw_rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(mode, 1'b0);
    check(wdt_en, 1'b1);
    check(jump_seen, 2);
    check(last_jump, sbl_pkg::RESET_VECTOR);
    check(rom_sel, 1'b0);
    check(use_ext, 1'b1);
    // hardware reset with strap high starts in normal mode
    @(posedge clk);
    rst <= 1'b1;
    strap <= 1'b1;
    ea <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(mode, 1'b0);
    check(use_ext, 1'b0);
    check(wdt_en, 1'b1);
    check(jump_addr, sbl_pkg::RESET_VECTOR);
    test_done();
  end
endmodule
